/* core/aphp_pkg.sv */
// package: constants and types shared by both ends of the parallel host port
// Contract
// R01: device drives result while select and read low
// R02: write strobe with select loads control register
// R03: read strobe high releases the data pins
// R04: falling edge on ready_n marks new result
// R05: ready_n held high during sync or calibration
// R06: bit 3 selects valid output or sync input
// R07: sync rising edge after low clock starts sync
// R08: pin pulled high; host avoids edges on switch
// R09: bit 0 standby, bit 2 bipolar range
// R10: writing one to bit 1 starts calibration
// R11: device clears calibration bit when done
// R12: host always writes zero to test bit 9
// R13: bipolar two's complement, unipolar straight binary
// R14: all strobes low at power-up selects serial
// R15: calibration at most 6720 or 9024 clocks
// R16: sync edge or standby aborts calibration
// R17: result msb on pin 11, lsb on pin 0
package aphp_pkg;
  localparam int DATA_W = 12;
  localparam int BIT_STANDBY = 0;
  localparam int BIT_CAL = 1;
  localparam int BIT_BIPOLAR = 2;
  localparam int BIT_PIN_FUNC = 3;
  localparam int BIT_TEST = 9;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [11:0] CTRL_WMASK = 12'h20F;
  localparam int CAL_UNI_CLKS = 6720;
  localparam int CAL_BIP_CLKS = 9024;
  localparam int SYNC_CLKS = 64;
  localparam int CONV_CLKS = 32;
  localparam int SERIAL_DELAY_CLKS = 2;
  localparam logic [13:0] CAL_UNI_CNT = 14'(CAL_UNI_CLKS - 1);
  localparam logic [13:0] CAL_BIP_CNT = 14'(CAL_BIP_CLKS - 1);
  localparam logic [13:0] SYNC_CNT = 14'(SYNC_CLKS - 1);
  localparam logic [13:0] CONV_CNT = 14'(CONV_CLKS - 1);
  localparam logic [11:0] MIDSCALE_FLIP = 12'h800;
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_IRQ_STATUS = 8'h08;
  localparam logic [7:0] APB_IRQ_MASK = 8'h0C;
  localparam logic [7:0] APB_RESULT = 8'h10;
  localparam int IRQ_NEW_RESULT = 0;
  localparam int IRQ_DONE = 1;
  localparam int CMD_GO_READ = 12;
  localparam int CMD_GO_WRITE = 13;
  localparam int CMD_PIN_DRIVE = 14;
  localparam int CMD_PIN_LEVEL = 15;
  localparam logic [2:0] PIN_SYNC_LOW_CLKS = 3'h2;
  typedef enum logic [1:0] {APHP_RUN, APHP_CAL, APHP_SYNC, APHP_STANDBY_BIT} aphp_mode_e;
  typedef enum logic [2:0] {APHP_IDLE, APHP_SETUP, APHP_STROBE, APHP_HOLD, APHP_FIN} aphp_host_e;
  // bipolar codes are the straight code with msb flipped (two's complement)
  function automatic logic [11:0] aphp_code(input logic [11:0] raw, input logic bipolar);
    aphp_code = bipolar ? (raw ^ MIDSCALE_FLIP) : raw;
  endfunction
endpackage

/* core/aphp_if.sv */
// interface: parallel host port pins between host and converter
`timescale 1ns/1ps
interface aphp_if;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic [11:0] host_d_out;
  logic        host_d_oe;
  logic [11:0] dev_d_out;
  logic        dev_d_oe;
  logic        result_ready_n;
  logic        pin_host_out;
  logic        pin_host_oe;
  logic        pin_dev_out;
  logic        pin_dev_oe;
  wire  [11:0] shared_data_pins = dev_d_oe ? dev_d_out : (host_d_oe ? host_d_out : 12'h000);
  // internal pull-up keeps the pin high when nobody drives it
  wire         valid_or_align_pin = pin_dev_oe ? pin_dev_out : (pin_host_oe ? pin_host_out : 1'b1);
  modport device (input cs_n, rd_n, wr_n, shared_data_pins, valid_or_align_pin,
                  output dev_d_out, dev_d_oe, result_ready_n, pin_dev_out, pin_dev_oe);
  modport host (input shared_data_pins, result_ready_n, valid_or_align_pin,
                output cs_n, rd_n, wr_n, host_d_out, host_d_oe, pin_host_out, pin_host_oe);
endinterface

/* core/aphp_device.sv */
// module: converter end of the parallel host port
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module aphp_device
  import aphp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  aphp_if.device           bus,
  input  wire logic [11:0] sample_raw,
  output logic             serial_mode,
  output logic             standby_bit,
  output logic             input_range_bipolar,
  output logic             factory_test_bit,
  output logic             cal_active
);
  logic [2:0]  cs_s, rd_s, wr_s, pin_s;
  logic [11:0] d_s1, d_s2, d_s3, d_word;
  logic [11:0] ctrl;
  aphp_mode_e  mode;
  logic [13:0] cnt;
  logic [11:0] result;
  logic        ready_n;
  logic        result_valid_out;
  logic        wr_q, pin_q;
  logic [1:0]  pin_low;
  logic [1:0]  pu_cnt;
  logic        pu_done;
  logic        pu_strobes_low;

  wire cs_n = (cs_s[2] == cs_s[1]) ? cs_s[1] : cs_s[2];
  wire rd_n = (rd_s[2] == rd_s[1]) ? rd_s[1] : rd_s[2];
  wire wr_n = (wr_s[2] == wr_s[1]) ? wr_s[1] : wr_s[2];
  wire pin_in = (pin_s[2] == pin_s[1]) ? pin_s[1] : pin_s[2];
  wire wr_rise = !wr_q && wr_n;
  wire write_done = wr_rise && !cs_n; // R02
  wire [11:0] next_ctrl = (d_word & CTRL_WMASK);
  wire sync_mode = ctrl[BIT_PIN_FUNC]; // R06
  // a sync edge counts only after the pin sat low a full clock
  wire sync_edge = sync_mode && pin_in && !pin_q && pin_low != 2'h0; // R07
  wire cal_start = write_done && next_ctrl[BIT_CAL] && !next_ctrl[BIT_STANDBY]; // R10
  wire standby_bit_now = ctrl[BIT_STANDBY]; // R09
  // a write that leaves standby falls through, so it may start calibration at once
  wire standby_bit_next = write_done ? next_ctrl[BIT_STANDBY] : standby_bit_now; // R09
  wire [13:0] cal_len = ctrl[BIT_BIPOLAR] ? CAL_BIP_CNT : CAL_UNI_CNT; // R15
  wire read_on = !cs_n && !rd_n && !serial_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_s <= 3'h7;
      rd_s <= 3'h7;
      wr_s <= 3'h7;
      pin_s <= 3'h7;
      wr_q <= 1'b1;
      pin_q <= 1'b1;
      pin_low <= 2'h0;
    end else if (clk_en) begin
      cs_s <= {cs_s[1:0], bus.cs_n};
      rd_s <= {rd_s[1:0], bus.rd_n};
      wr_s <= {wr_s[1:0], bus.wr_n};
      pin_s <= {pin_s[1:0], bus.valid_or_align_pin};
      wr_q <= wr_n;
      pin_q <= pin_in;
      pin_low <= pin_in ? 2'h0 : (pin_low == 2'h3 ? pin_low : pin_low + 2'h1);
    end
  end

  // data pins run through the same three stages as the write strobe, so the
  // word held is the one seen at the strobe's last low sample; the host may
  // already have released the pins when the synced rising edge arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_s1 <= 12'h000;
      d_s2 <= 12'h000;
      d_s3 <= 12'h000;
      d_word <= 12'h000;
    end else if (clk_en) begin
      d_s1 <= bus.shared_data_pins;
      d_s2 <= d_s1;
      d_s3 <= d_s2;
      if (!wr_n)
        d_word <= d_s3;
    end
  end

  // strobes caught at power-up decide the interface mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_cnt <= 2'h0;
      pu_done <= 1'b0;
      pu_strobes_low <= 1'b0;
      serial_mode <= 1'b0;
    end else if (clk_en && !pu_done) begin
      pu_strobes_low <= !bus.cs_n && !bus.rd_n && !bus.wr_n;
      pu_cnt <= pu_cnt + 2'h1;
      if (pu_cnt == 2'(SERIAL_DELAY_CLKS)) begin
        pu_done <= 1'b1;
        serial_mode <= pu_strobes_low; // R14
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      mode <= APHP_RUN;
      cnt <= 14'h0000;
      result <= 12'h000;
      ready_n <= 1'b1;
      result_valid_out <= 1'b0;
    end else if (clk_en) begin
      if (write_done)
        ctrl <= next_ctrl; // R02
      if (mode == APHP_CAL && cnt == 14'h0000 && !sync_edge && !standby_bit_now)
        ctrl[BIT_CAL] <= 1'b0; // R11
      if (standby_bit_next) begin
        mode <= APHP_STANDBY_BIT; // R16
        ctrl[BIT_CAL] <= 1'b0;
        ready_n <= 1'b1;
        result_valid_out <= 1'b0;
      end else if (sync_edge) begin
        mode <= APHP_SYNC; // R16
        cnt <= SYNC_CNT;
        ctrl[BIT_CAL] <= 1'b0;
        ready_n <= 1'b1; // R05
        result_valid_out <= 1'b0;
      end else if (cal_start) begin
        mode <= APHP_CAL;
        cnt <= next_ctrl[BIT_BIPOLAR] ? CAL_BIP_CNT : CAL_UNI_CNT;
        ready_n <= 1'b1; // R05
        result_valid_out <= 1'b0;
      end else begin
        unique case (mode)
          APHP_RUN, APHP_STANDBY_BIT: begin
            if (mode == APHP_STANDBY_BIT)
              cnt <= CONV_CNT;
            else if (cnt == 14'h0000) begin
              cnt <= CONV_CNT;
              result <= aphp_code(sample_raw, ctrl[BIT_BIPOLAR]); // R13
              ready_n <= 1'b0; // R04
              result_valid_out <= 1'b1;
            end else begin
              cnt <= cnt - 14'h0001;
              if (cnt == 14'h0001)
                ready_n <= 1'b1;
              result_valid_out <= 1'b0;
            end
            mode <= APHP_RUN;
          end
          APHP_CAL, APHP_SYNC: begin
            ready_n <= 1'b1; // R05
            if (cnt == 14'h0000 || cnt > cal_len) begin
              mode <= APHP_RUN;
              cnt <= 14'h0000;
            end else
              cnt <= cnt - 14'h0001;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.dev_d_out <= 12'h000;
      bus.dev_d_oe <= 1'b0;
      bus.result_ready_n <= 1'b1;
      bus.pin_dev_out <= 1'b0;
      bus.pin_dev_oe <= 1'b0;
      standby_bit <= 1'b0;
      input_range_bipolar <= 1'b0;
      factory_test_bit <= 1'b0;
      cal_active <= 1'b0;
    end else if (clk_en) begin
      bus.dev_d_out <= result; // R17
      bus.dev_d_oe <= read_on; // R01 R03
      bus.result_ready_n <= ready_n;
      bus.pin_dev_out <= result_valid_out;
      bus.pin_dev_oe <= !sync_mode; // R06 R08
      standby_bit <= ctrl[BIT_STANDBY];
      input_range_bipolar <= ctrl[BIT_BIPOLAR];
      factory_test_bit <= ctrl[BIT_TEST];
      cal_active <= mode == APHP_CAL;
    end
  end
endmodule

/* core/aphp_host.sv */
// module: host controller end, ordered over apb
`timescale 1ns/1ps
module aphp_host
  import aphp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  aphp_if.host             bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  logic [11:0] wdata;
  logic        busy, is_read;
  aphp_host_e  st;
  logic [2:0]  cnt;
  logic [11:0] rdata;
  logic [1:0]  irq_st, irq_mask;
  logic        pin_drive, pin_level;
  logic [2:0]  rdy_s;
  logic        rdy_q;

  wire access = psel && penable && !pready;
  wire sel_cmd = paddr == APB_CMD;
  wire sel_sta = paddr == APB_STATUS;
  wire sel_ist = paddr == APB_IRQ_STATUS;
  wire sel_msk = paddr == APB_IRQ_MASK;
  wire sel_res = paddr == APB_RESULT;
  wire mapped = sel_cmd || sel_sta || sel_ist || sel_msk || sel_res;
  wire wr_cmd = access && pwrite && sel_cmd && !busy;
  wire go_rd = wr_cmd && pwdata[CMD_GO_READ];
  wire go_wr = wr_cmd && pwdata[CMD_GO_WRITE] && !pwdata[CMD_GO_READ];
  wire rdy_n = (rdy_s[2] == rdy_s[1]) ? rdy_s[1] : rdy_s[2];
  wire ev_new = rdy_q && !rdy_n;
  wire ev_done = st == APHP_FIN;
  wire [1:0] ev = {ev_done, ev_new};
  wire [31:0] rd_mux = sel_cmd ? {18'h00000, pin_level, pin_drive, wdata} :
                       sel_sta ? {30'h00000000, !rdy_n, busy} :
                       sel_ist ? {30'h00000000, irq_st} :
                       sel_msk ? {30'h00000000, irq_mask} :
                       sel_res ? {20'h00000, rdata} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      wdata <= 12'h000;
      irq_mask <= 2'h0;
      irq_st <= 2'h0;
      pin_drive <= 1'b0;
      pin_level <= 1'b1;
      rdy_s <= 3'h7;
      rdy_q <= 1'b1;
      irq <= 1'b0;
    end else if (clk_en) begin
      rdy_s <= {rdy_s[1:0], bus.result_ready_n};
      rdy_q <= rdy_n;
      pready <= access;
      pslverr <= access && !mapped;
      prdata <= (access && !pwrite) ? rd_mux : 32'h00000000;
      if (wr_cmd) begin
        wdata <= pwdata[11:0] & ~(12'h001 << BIT_TEST); // R12
        pin_drive <= pwdata[CMD_PIN_DRIVE];
        pin_level <= pwdata[CMD_PIN_LEVEL] | pwdata[CMD_GO_READ];
      end
      if (access && pwrite && sel_msk)
        irq_mask <= pwdata[1:0];
      // a new event wins over the write-one clear in the same cycle
      irq_st <= (irq_st & ~((access && pwrite && sel_ist) ? pwdata[1:0] : 2'h0)) | ev;
      irq <= |(irq_st & irq_mask);
    end
  end

  // strobe sequence: setup, hold strobe low, release, then settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= APHP_IDLE;
      busy <= 1'b0;
      is_read <= 1'b0;
      cnt <= 3'h0;
      rdata <= 12'h000;
      bus.cs_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.wr_n <= 1'b1;
      bus.host_d_out <= 12'h000;
      bus.host_d_oe <= 1'b0;
      bus.pin_host_out <= 1'b1;
      bus.pin_host_oe <= 1'b0;
    end else if (clk_en) begin
      // pin is released high so the pull-up gives no rising edge
      bus.pin_host_oe <= pin_drive; // R08
      bus.pin_host_out <= pin_level; // R07
      unique case (st)
        APHP_IDLE: begin
          cnt <= 3'h0;
          if (go_rd || go_wr) begin
            st <= APHP_SETUP;
            busy <= 1'b1;
            is_read <= go_rd;
            bus.cs_n <= 1'b0;
            bus.host_d_out <= pwdata[11:0] & ~(12'h001 << BIT_TEST); // R12
            bus.host_d_oe <= go_wr;
          end
        end
        APHP_SETUP: begin
          st <= APHP_STROBE;
          bus.rd_n <= !is_read; // R01
          bus.wr_n <= is_read; // R02
        end
        APHP_STROBE: begin
          cnt <= cnt + 3'h1;
          if (cnt == 3'h5) begin
            st <= APHP_HOLD;
            if (is_read)
              rdata <= bus.shared_data_pins; // R17
            bus.rd_n <= 1'b1; // R03
            bus.wr_n <= 1'b1;
          end
        end
        APHP_HOLD: begin
          st <= APHP_FIN;
          bus.cs_n <= 1'b1;
          bus.host_d_oe <= 1'b0;
        end
        APHP_FIN: begin
          st <= APHP_IDLE;
          busy <= 1'b0;
        end
        default: st <= APHP_IDLE;
      endcase
    end
  end
endmodule

/* sim/aphp_monitor.sv */
// checker: pin-level relations between host and converter ends
`timescale 1ns/1ps
module aphp_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic host_d_oe,
  input wire logic dev_d_oe,
  input wire logic result_ready_n,
  input wire logic pin_host_oe,
  input wire logic pin_dev_oe,
  input wire logic valid_or_align_pin
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_read_held;
    (!cs_n && !rd_n) [*6];
  endsequence
  sequence s_sync_edge;
    pin_host_oe && $rose(valid_or_align_pin);
  endsequence
  a_drive_on_read: assert property (s_read_held |-> dev_d_oe)
    else $error("data pins not driven during read");
  a_release_on_idle: assert property (rd_n [*8] |-> !dev_d_oe)
    else $error("data pins still driven with read high");
  a_no_contention: assert property (!(dev_d_oe && host_d_oe))
    else $error("both ends drive the data pins");
  a_write_selected: assert property (!wr_n |-> !cs_n && host_d_oe)
    else $error("write strobe without select or data");
  a_one_strobe: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes low together");
  a_read_width: assert property ($fell(rd_n) |-> !rd_n [*6])
    else $error("read strobe too short");
  a_ready_returns: assert property ($fell(result_ready_n) |-> ##[1:40] result_ready_n)
    else $error("ready stays low beyond a conversion");
  a_sync_holds_ready: assert property (s_sync_edge |-> ##[1:8] result_ready_n [*8])
    else $error("ready not held high after sync edge");
  a_pin_one_driver: assert property (!(pin_dev_oe && pin_host_oe))
    else $error("both ends drive the dual pin");
endmodule

/* sim/tb_top.sv */
// testbench: host and converter ends joined, driven over apb
`timescale 1ns/1ps
module tb_top import aphp_pkg::*; ;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [11:0] sample_raw;
  logic        serial_mode;
  logic        standby_bit;
  logic        bipolar;
  logic        test_bit;
  logic        cal_active;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          tests_run;
  int          cycles;
  aphp_if bus ();
  aphp_device u_aphp_device (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .bus(bus), .sample_raw(sample_raw),
    .serial_mode(serial_mode), .standby_bit(standby_bit), .input_range_bipolar(bipolar),
    .factory_test_bit(test_bit), .cal_active(cal_active));
  aphp_host u_aphp_host (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .bus(bus), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  aphp_monitor u_aphp_monitor (.pclk(pclk), .presetn(presetn), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
    .wr_n(bus.wr_n), .host_d_oe(bus.host_d_oe), .dev_d_oe(bus.dev_d_oe), .result_ready_n(bus.result_ready_n),
    .pin_host_oe(bus.pin_host_oe), .pin_dev_oe(bus.pin_dev_oe), .valid_or_align_pin(bus.valid_or_align_pin));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // f holds pin level, pin drive, go write, go read
  task automatic cmd(input logic [3:0] f, input logic [11:0] v);
    int n;
    apb(1'b1, APB_CMD, {16'h0000, f, v});
    n = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 50);
  endtask
  // control load goes through the device's synchronisers, so allow a few clocks
  task automatic ctrl(input logic [11:0] v);
    cmd(4'h2, v);
    repeat (8) @(posedge pclk);
  endtask
  task automatic t_regs();
    check("serial", serial_mode, 1'b0);
    ctrl(12'h200);
    check("testbit pin", test_bit, 1'b0);
    apb(1'b0, APB_CMD, 32'h0);
    check("testbit", rd[11:0], 12'h000);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
  endtask
  task automatic t_codes();
    for (int i = 0; i < 4; i++) begin
      sample_raw <= i[0] ? 12'hFFF : 12'h3A5;
      ctrl({9'h000, i[1], 2'b00});
      check("range", bipolar, i[1]);
      check("standby", standby_bit, 1'b0);
      repeat (40) @(posedge pclk);
      cmd(4'h1, 12'h000);
      apb(1'b0, APB_RESULT, 32'h0);
      check("result", rd[11:0], (i[0] ? 12'hFFF : 12'h3A5) ^ (i[1] ? 12'h800 : 12'h000));
    end
  endtask
  task automatic t_irq();
    int n;
    apb(1'b1, APB_IRQ_STATUS, 32'h3);
    apb(1'b1, APB_IRQ_MASK, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 80) begin
      @(posedge pclk);
      n++;
    end
    check("irq ready", irq, 1'b1);
    apb(1'b1, APB_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    check("irq masked", irq, 1'b0);
    apb(1'b1, APB_IRQ_STATUS, 32'h3);
    apb(1'b0, APB_IRQ_STATUS, 32'h0);
    check("done clr", rd[1], 1'b0);
    apb(1'b1, APB_IRQ_MASK, 32'h2);
    cmd(4'h1, 12'h000);
    repeat (2) @(posedge pclk);
    check("irq done", irq, 1'b1);
    apb(1'b1, APB_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge pclk);
    check("irq clr", irq, 1'b0);
    apb(1'b1, APB_IRQ_MASK, 32'h0);
  endtask
  task automatic t_cal();
    int n;
    logic hi;
    ctrl(12'h002);
    check("cal on", cal_active, 1'b1);
    ctrl(12'h003);
    check("cal standby_bit", cal_active, 1'b0);
    check("rdy standby_bit", bus.result_ready_n, 1'b1);
    ctrl(12'h006);
    n = 0;
    hi = 1'b1;
    while (cal_active === 1'b1 && n < 9100) begin
      @(posedge pclk);
      hi &= bus.result_ready_n;
      n++;
    end
    check("cal len", n <= CAL_BIP_CLKS, 1'b1);
    check("cal bip", n > CAL_UNI_CLKS, 1'b1);
    check("cal rdy", hi, 1'b1);
    check("cal end", cal_active, 1'b0);
  endtask
  task automatic t_sync();
    // entering sync mode lets the pull-up lift the pin, so arm calibration only after that
    ctrl(12'h008);
    check("result_valid_out off", bus.pin_dev_oe, 1'b0);
    ctrl(12'h00A);
    check("cal armed", cal_active, 1'b1);
    cmd(4'h4, 12'h00A);
    cmd(4'hC, 12'h00A);
    repeat (6) @(posedge pclk);
    check("sync abort", cal_active, 1'b0);
    repeat (30) @(posedge pclk);
    check("sync rdy", bus.result_ready_n, 1'b1);
    cmd(4'h0, 12'h008);
    check("pull up", bus.valid_or_align_pin, 1'b1);
    ctrl(12'h000);
    check("result_valid_out on", bus.pin_dev_oe, 1'b1);
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, sample_raw} = '0;
    {fails, tests_run, cycles} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_codes();
    t_irq();
    t_cal();
    t_sync();
    test_done();
  end
endmodule
